// file: asc_host.sv
`default_nettype none
// Functional notes
// [R1] Write spans overlap of all qualifiers
// [R2] Any qualifier deasserting ends the write
// [R3] Setup/hold measured from terminating edge
// [R4] Output gate high keeps memory floating
// [R5] Simultaneous deselect leaves outputs floating
// [R6] Never drive while memory drives
// [R7] Strobe pulse covers float plus setup
// [R8] Both lanes read gives full word
// [R9] Lower lane read uses lines 0-7
// [R10] Upper lane read uses lines 8-15
// [R11] Both lanes write stores full word
// [R12] Lower lane write keeps high byte
// [R13] Upper lane write keeps low byte
// [R14] Don't-care selects held at valid levels
// [R15] Deselect floats data, ignores inputs
// [R16] Read returns last written lane value
module asc_host import asc_pkg::*; #(
	parameter int WR_PULSE_CYC = ASC_WR_PULSE_CYC,
	parameter int RD_CYC = ASC_RD_CYC,
	parameter int FLOAT_CYC = ASC_FLOAT_CYC
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// User request
	input wire logic i_req_valid,
	input wire asc_req_t i_req,
	output logic o_req_ready,
	// User answer
	output logic o_rd_valid,
	output logic [ASC_DATA_W-1:0] o_rd_data,
	// Memory control pins
	output asc_ctl_t o_ctl,
	output logic [ASC_ADDR_W-1:0] o_addr,
	// Memory data pins, split
	input wire logic [ASC_DATA_W-1:0] i_data,
	output logic [ASC_DATA_W-1:0] o_data,
	output logic [1:0] o_data_oe
);
	// Counts must fit the counter and be at least one cycle, the read count at least two
	initial begin
		if (WR_PULSE_CYC < 1 || WR_PULSE_CYC >= 2 ** ASC_CNT_W || RD_CYC < 2 ||
			RD_CYC + ASC_SYNC_LAT >= 2 ** ASC_CNT_W ||
			FLOAT_CYC < 1 || FLOAT_CYC >= 2 ** ASC_CNT_W) begin
			$error("asc_host: timing count out of range");
		end
	end
	typedef struct packed {
		asc_state_t state;
		logic [ASC_CNT_W-1:0] cnt;
		logic [1:0] lanes;
		logic ready;
		logic rd_valid;
		logic [ASC_DATA_W-1:0] rd_data;
		asc_ctl_t ctl;
		logic [ASC_ADDR_W-1:0] addr;
		logic [ASC_DATA_W-1:0] wdata;
		logic [1:0] oe;
	} asc_host_st_t;
	asc_host_st_t st_r;
	asc_host_st_t st_nxt;
	logic [ASC_DATA_W-1:0] data_sync;
	// Read data comes back from pins outside this clock
	asc_sync3 #(
		.WIDTH(ASC_DATA_W)
	) u_sync (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_async(i_data),
		.o_sync(data_sync)
	);
	always_comb begin
		st_nxt = st_r;
		st_nxt.rd_valid = 1'b0;
		case (st_r.state)
			ASC_IDLE: begin
				// Selects stay at a solid idle level, never released
				st_nxt.ctl = ASC_CTL_IDLE; // [R14]
				st_nxt.oe = 2'b00;
				st_nxt.ready = 1'b1;
				if (st_r.ready && i_req_valid && i_req.lanes != 2'b00) begin
					st_nxt.ready = 1'b0;
					st_nxt.addr = i_req.addr;
					st_nxt.lanes = i_req.lanes;
					st_nxt.wdata = i_req.wdata;
					st_nxt.ctl.chip_select_n = 1'b0;
					st_nxt.ctl.chip_select_hi = 1'b1;
					st_nxt.ctl.upper_lane_sel_n = ~i_req.lanes[1];
					st_nxt.ctl.lower_lane_sel_n = ~i_req.lanes[0];
					st_nxt.cnt = '0;
					if (i_req.write) begin
						// Gate stays high so the memory never drives during a write
						st_nxt.ctl.output_gate_n = 1'b1; // [R6] [R4]
						st_nxt.state = ASC_WSETUP;
					end else begin
						st_nxt.ctl.output_gate_n = 1'b0; // [R8] [R9] [R10]
						st_nxt.state = ASC_READ;
					end
				end
			end
			ASC_WSETUP: begin
				// Address settled; drive only selected lanes and open the strobe on the same edge
				st_nxt.oe = st_r.lanes; // [R12] [R13] [R11]
				st_nxt.ctl.write_strobe_n = 1'b0; // [R1]
				st_nxt.cnt = '0;
				st_nxt.state = ASC_WPULSE;
			end
			ASC_WPULSE: begin
				// Pulse long enough for float plus data setup
				if (st_r.cnt == ASC_CNT_W'(WR_PULSE_CYC - 1)) begin // [R7]
					st_nxt.ctl.write_strobe_n = 1'b1; // [R2]
					st_nxt.state = ASC_WHOLD;
				end else begin
					st_nxt.cnt = st_r.cnt + 1'b1;
				end
			end
			ASC_WHOLD: begin
				// Strobe terminates; data held one cycle past that edge
				st_nxt.oe = 2'b00; // [R3]
				st_nxt.ctl = ASC_CTL_IDLE;
				st_nxt.state = ASC_IDLE;
			end
			ASC_READ: begin
				// Gate held low until the pins have passed the synchroniser
				if (st_r.cnt == ASC_CNT_W'(RD_CYC + ASC_SYNC_LAT - 1)) begin
					// Sample through synchroniser, keep only selected lanes
					for (int b = 0; b < 2; b++) begin
						st_nxt.rd_data[b*ASC_LANE_W +: ASC_LANE_W] = st_r.lanes[b] ?
							data_sync[b*ASC_LANE_W +: ASC_LANE_W] : '0; // [R16] [R9] [R10]
					end
					st_nxt.rd_valid = 1'b1;
					// Chip selects and gate drop together: memory floats cleanly
					st_nxt.ctl = ASC_CTL_IDLE; // [R5] [R15]
					st_nxt.cnt = '0;
					st_nxt.state = ASC_RFLOAT;
				end else begin
					st_nxt.cnt = st_r.cnt + 1'b1;
				end
			end
			ASC_RFLOAT: begin
				// Wait out the float time before any later write drives
				if (st_r.cnt == ASC_CNT_W'(FLOAT_CYC - 1)) begin // [R6]
					st_nxt.state = ASC_IDLE;
					st_nxt.ready = 1'b1;
				end else begin
					st_nxt.cnt = st_r.cnt + 1'b1;
				end
			end
			default: begin
				st_nxt.state = ASC_IDLE;
				st_nxt.ctl = ASC_CTL_IDLE;
				st_nxt.oe = 2'b00;
			end
		endcase
	end
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			st_r <= '0;
			st_r.state <= ASC_IDLE;
			st_r.ctl <= ASC_CTL_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end
	// All pins straight from state flops
	assign o_req_ready = st_r.ready;
	assign o_rd_valid = st_r.rd_valid;
	assign o_rd_data = st_r.rd_data;
	assign o_ctl = st_r.ctl;
	assign o_addr = st_r.addr;
	assign o_data = st_r.wdata;
	assign o_data_oe = st_r.oe;
endmodule : asc_host
`default_nettype wire

// file: asc_pkg.sv
`default_nettype none
package asc_pkg;
	// Bus geometry
	localparam int ASC_ADDR_W = 20;
	localparam int ASC_DATA_W = 16;
	localparam int ASC_LANE_W = 8;
	// Clock period and device timing, in ns
	localparam int ASC_CLK_PERIOD_NS = 4;
	localparam int ASC_STROBE_TO_FLOAT_NS = 18;
	localparam int ASC_DATA_SETUP_NS = 25;
	localparam int ASC_WRITE_PULSE_NS = 35;
	localparam int ASC_READ_CYCLE_NS = 45;
	localparam int ASC_OE_FLOAT_NS = 18;
	// Least times round up to whole cycles
	localparam int ASC_WR_PULSE_CYC = (((ASC_WRITE_PULSE_NS > ASC_STROBE_TO_FLOAT_NS + ASC_DATA_SETUP_NS) ?
		ASC_WRITE_PULSE_NS : ASC_STROBE_TO_FLOAT_NS + ASC_DATA_SETUP_NS) + ASC_CLK_PERIOD_NS - 1) / ASC_CLK_PERIOD_NS;
	localparam int ASC_RD_CYC = (ASC_READ_CYCLE_NS + ASC_CLK_PERIOD_NS - 1) / ASC_CLK_PERIOD_NS;
	localparam int ASC_FLOAT_CYC = (ASC_OE_FLOAT_NS + ASC_CLK_PERIOD_NS - 1) / ASC_CLK_PERIOD_NS;
	localparam int ASC_SETUP_CYC = (ASC_DATA_SETUP_NS + ASC_CLK_PERIOD_NS - 1) / ASC_CLK_PERIOD_NS;
	localparam int ASC_CNT_W = 8;
	// Edges from a pin change to the settled synchroniser output
	localparam int ASC_SYNC_LAT = 4;
	// Pin group driven to the memory
	typedef struct packed {
		logic chip_select_n;
		logic chip_select_hi;
		logic write_strobe_n;
		logic output_gate_n;
		logic upper_lane_sel_n;
		logic lower_lane_sel_n;
	} asc_ctl_t;
	localparam asc_ctl_t ASC_CTL_IDLE = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
	// User request
	typedef struct packed {
		logic write;
		logic [1:0] lanes;
		logic [ASC_ADDR_W-1:0] addr;
		logic [ASC_DATA_W-1:0] wdata;
	} asc_req_t;
	typedef enum logic [2:0] {
		ASC_IDLE = 3'b000,
		ASC_WSETUP = 3'b001,
		ASC_WPULSE = 3'b011,
		ASC_WHOLD = 3'b010,
		ASC_READ = 3'b110,
		ASC_RFLOAT = 3'b111
	} asc_state_t;
endpackage : asc_pkg
`default_nettype wire

// file: asc_sync3.sv
`default_nettype none
module asc_sync3 import asc_pkg::*; #(
	parameter int WIDTH = 16
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Asynchronous pins in, settled value out
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] val;
	} asc_sync_st_t;
	asc_sync_st_t st_r;
	asc_sync_st_t st_nxt;
	// First stage feeds only the second; accept once second and third agree
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = i_async;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		for (int i = 0; i < WIDTH; i++) begin
			if (st_r.s2[i] == st_r.s3[i]) begin
				st_nxt.val[i] = st_r.s3[i];
			end
		end
	end
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign o_sync = st_r.val;
endmodule : asc_sync3
`default_nettype wire

// file: asc_chk.sv
`default_nettype none
module asc_chk import asc_pkg::*; #(
	parameter int WR_PULSE_CYC = 11,
	parameter int RD_CYC = 12
) (
	// Watched ports
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_req_valid,
	input wire asc_req_t i_req,
	input wire logic o_req_ready,
	input wire logic o_rd_valid,
	input wire logic [ASC_DATA_W-1:0] o_rd_data,
	input wire asc_ctl_t o_ctl,
	input wire logic [ASC_ADDR_W-1:0] o_addr,
	input wire logic [ASC_DATA_W-1:0] i_data,
	input wire logic [ASC_DATA_W-1:0] o_data,
	input wire logic [1:0] o_data_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int RDL = RD_CYC + ASC_SYNC_LAT + 1;
	logic [7:0] lo_r;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	// Strobe low cycle count
	always_ff @(posedge i_clk) lo_r <= (i_reset || o_ctl.write_strobe_n) ? 8'h0 : lo_r + 8'h1;
	a_write_qual: assert property (!o_ctl.write_strobe_n |-> !o_ctl.chip_select_n && o_ctl.chip_select_hi &&
		o_ctl.output_gate_n && {o_ctl.upper_lane_sel_n, o_ctl.lower_lane_sel_n} != 2'b11) else $error("bad write");
	a_strobe_len: assert property ($rose(o_ctl.write_strobe_n) |-> lo_r == 8'(WR_PULSE_CYC))
		else $error("strobe length");
	a_end_idle: assert property ($rose(o_ctl.write_strobe_n) |-> ##1 o_data_oe == 2'b00 && o_ctl == ASC_CTL_IDLE)
		else $error("no release");
	a_data_hold: assert property ($rose(o_ctl.write_strobe_n) |-> $stable(o_data) && o_data_oe != 2'b00)
		else $error("data hold");
	a_no_clash: assert property (!o_ctl.output_gate_n |-> o_data_oe == 2'b00) else $error("contention");
	a_lane_oe: assert property (o_data_oe != 2'b00 |-> !o_ctl.chip_select_n &&
		o_data_oe == ~{o_ctl.upper_lane_sel_n, o_ctl.lower_lane_sel_n}) else $error("lane drive");
	a_rd_answer: assert property (o_req_ready && i_req_valid && !i_req.write && i_req.lanes != 2'b00 |-> ##RDL o_rd_valid)
		else $error("no read answer");
	c_write: cover property ($rose(o_ctl.write_strobe_n));
	c_read: cover property (o_rd_valid);
	c_low: cover property (o_data_oe == 2'b01);
endmodule : asc_chk
bind asc_host asc_chk #(.WR_PULSE_CYC(WR_PULSE_CYC), .RD_CYC(RD_CYC)) u_chk (.i_clk(i_clk), .i_reset(i_reset),
	.i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready), .o_rd_valid(o_rd_valid),
	.o_rd_data(o_rd_data), .o_ctl(o_ctl), .o_addr(o_addr), .i_data(i_data), .o_data(o_data), .o_data_oe(o_data_oe));
`default_nettype wire

// file: asc_sram_mdl.sv
`default_nettype none
module asc_sram_mdl import asc_pkg::*; (
	// Pins from host
	input wire asc_ctl_t i_ctl,
	input wire logic [ASC_ADDR_W-1:0] i_addr,
	input wire logic [ASC_DATA_W-1:0] i_data,
	input wire logic [1:0] i_oe,
	// Resolved bus
	output logic [ASC_DATA_W-1:0] o_q
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [16];
	logic [15:0] m;
	logic [1:0] ln;
	logic [1:0] dr;
	logic sel;
	// Selection and lane decode
	assign ln = ~{i_ctl.upper_lane_sel_n, i_ctl.lower_lane_sel_n};
	assign sel = !i_ctl.chip_select_n && i_ctl.chip_select_hi && ln != 2'b00;
	assign m = mem[i_addr[3:0]];
	assign dr = (sel && i_ctl.write_strobe_n && !i_ctl.output_gate_n) ? ln : 2'b00;
	// Floating lanes show inverted byte, so stale data never passes
	assign o_q[7:0] = i_oe[0] ? i_data[7:0] : (dr[0] ? m[7:0] : ~m[7:0]);
	assign o_q[15:8] = i_oe[1] ? i_data[15:8] : (dr[1] ? m[15:8] : ~m[15:8]);
	// Storage follows data for the whole overlap
	always @* begin
		if (sel && !i_ctl.write_strobe_n) begin
			if (ln[0]) mem[i_addr[3:0]][7:0] = i_oe[0] ? i_data[7:0] : 8'hxx;
			if (ln[1]) mem[i_addr[3:0]][15:8] = i_oe[1] ? i_data[15:8] : 8'hxx;
		end
	end
endmodule : asc_sram_mdl
`default_nettype wire

// file: test_async_sram_byte_lane_access.sv
`default_nettype none
module test_async_sram_byte_lane_access import asc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk = 0, i_reset = 1, vld = 0, rdy, rv;
	asc_req_t rq = '0;
	asc_ctl_t ctl;
	logic [15:0] rd, dq, dout;
	logic [19:0] ad;
	logic [1:0] oe;
	int error_cnt = 0, checks_done = 0;
	asc_host #(.WR_PULSE_CYC(1), .RD_CYC(2), .FLOAT_CYC(1)) dut (.i_clk(i_clk), .i_reset(i_reset),
		.i_req_valid(vld), .i_req(rq), .o_req_ready(rdy), .o_rd_valid(rv), .o_rd_data(rd), .o_ctl(ctl),
		.o_addr(ad), .i_data(dq), .o_data(dout), .o_data_oe(oe));
	asc_sram_mdl mdl (.i_ctl(ctl), .i_addr(ad), .i_data(dout), .i_oe(oe), .o_q(dq));
	// Clock, 4 ns period
	initial forever #2 i_clk = ~i_clk;
	task automatic check(string n, logic [15:0] s, logic [15:0] e);
		checks_done++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : check
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : give_verdict
	// Ready is a register, so looking at it on the falling edge is race free
	task automatic access(logic w, logic [1:0] l, logic [19:0] a, logic [15:0] d);
		int n = 0;
		@(negedge i_clk);
		vld = 1;
		rq = '{w, l, a, d};
		while (!rdy && n < 100) begin
			@(negedge i_clk);
			n++;
		end
		@(negedge i_clk);
		vld = 0;
	endtask : access
	task automatic rd_chk(string nm, logic [1:0] l, logic [19:0] a, logic [15:0] e);
		int n = 0;
		access(1'b0, l, a, 16'h0);
		while (!rv && n < 50) begin
			@(posedge i_clk);
			#1 n++;
		end
		check("read answer", 16'(rv), 16'h1);
		check(nm, rd, e);
	endtask : rd_chk
	task automatic t_full;
		for (int i = 0; i < 4; i++) access(1'b1, 2'b11, 20'(i), 16'h1234 ^ 16'(i));
		for (int i = 0; i < 4; i++) rd_chk("full word", 2'b11, 20'(i), 16'h1234 ^ 16'(i));
		$display("test full done");
	endtask : t_full
	task automatic t_lanes;
		access(1'b1, 2'b11, 20'h5, 16'h1234);
		access(1'b1, 2'b01, 20'h5, 16'hffab);
		rd_chk("low write", 2'b11, 20'h5, 16'h12ab);
		access(1'b1, 2'b10, 20'h5, 16'hcdff);
		rd_chk("high write", 2'b11, 20'h5, 16'hcdab);
		rd_chk("low read", 2'b01, 20'h5, 16'h00ab);
		rd_chk("high read", 2'b10, 20'h5, 16'hcd00);
		$display("test lanes done");
	endtask : t_lanes
	task automatic t_drop;
		access(1'b1, 2'b00, 20'h5, 16'h0000);
		check("drop ctl", 16'(ctl), 16'(ASC_CTL_IDLE));
		check("drop ready", 16'(rdy), 16'h1);
		rd_chk("drop keep", 2'b11, 20'h5, 16'hcdab);
		$display("test drop done");
	endtask : t_drop
	// Main sequence, reset held 5 cycles
	initial begin
		repeat (5) @(negedge i_clk);
		i_reset = 0;
		t_full;
		t_lanes;
		t_drop;
		give_verdict;
	end
	// Watchdog
	initial begin
		#20000;
		error_cnt++;
		give_verdict;
	end
endmodule : test_async_sram_byte_lane_access
`default_nettype wire
